// ### pkg/ccs_pkg.sv
// Overview of operation
// RULE_01: Twenty-two write-only select bits across three byte registers pick clock sources.
// RULE_02: Each counter one to ten owns a first and a second select bit.
// RULE_03: First byte: bits 7..4 first bits of counters 1-4, bits 3..0 second bits 4-1.
// RULE_04: Second byte: bits 7..4 first bits of counters 5-8, bits 3..0 second bits 8-5.
// RULE_05: Third byte: 9,10 first bits, aux source, debounce clock, 10,9 second bits.
// RULE_06: Eight input lines read back as one byte, line k in bit k.
// RULE_07: Write at the port address drives eight output lines; a read returns inputs.
// RULE_08: Ten independent 16-bit down counters whose clocks can be chained.
// RULE_09: A fixed internal 8 MHz reference is a selectable counter clock.
// RULE_10: A fixed internal 2 MHz reference is a selectable counter clock.
// RULE_11: Cascade selection clocks a counter from the previous counter's output; the code cascades counter 1 from aux_tick instead.
// RULE_12: An unconnected gate reads enabled; a connected gate controls counting.
// RULE_13: External clocks may pass a per-counter debounce filter on the debounce clock.
// RULE_14: Two interrupt sources: one from the counters, one from an external input.
// RULE_15: Counter 11 runs from 8 MHz, counter 12 from counter 11; both fixed.
// RULE_16: Select encoding and reset values are chosen by this design.
package ccs_pkg;
  localparam int ADDR_W = 12;
  localparam int NSEL = 10;
  localparam int NCNT = 12;
  localparam int CNT_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_SEL0 = 12'h0010;
  localparam logic [ADDR_W-1:0] IDX_SEL1 = 12'h0011;
  localparam logic [ADDR_W-1:0] IDX_SEL2 = 12'h0012;
  localparam logic [ADDR_W-1:0] IDX_DIO = 12'h0018;
  localparam logic [ADDR_W-1:0] ADDR_SEL0 = IDX_SEL0 << 2;
  localparam logic [ADDR_W-1:0] ADDR_SEL1 = IDX_SEL1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_SEL2 = IDX_SEL2 << 2;
  localparam logic [ADDR_W-1:0] ADDR_DIO = IDX_DIO << 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h0070;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h0074;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 12'h0080;
  // Bit positions in the third select byte
  localparam int POS_AUX_SEL = 5;
  localparam int POS_DEB_SEL = 4;
  // Interrupt status bits
  localparam int IRQ_INT = 0;
  localparam int IRQ_EXT = 1;
  localparam int NIRQ = 2;
  // Reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] DOUT_RESET = 8'h00;
  localparam logic [NIRQ-1:0] MASK_RESET = 2'b00;
  localparam logic [CNT_W-1:0] RELOAD_RESET = 16'h0000;
  // Reference rates in MHz; ticks come from a phase accumulator
  localparam int CLK_MHZ = 250;
  localparam int REF_HI_MHZ = 8;
  localparam int REF_LO_MHZ = 2;
  localparam int ACC_W = 9;
  // Two-bit select codes {first, second}
  typedef enum logic [1:0] {
    CCS_SRC_HI  = 2'b00,
    CCS_SRC_LO  = 2'b01,
    CCS_SRC_EXT = 2'b10,
    CCS_SRC_CAS = 2'b11
  } ccs_src_t;
  // Pin inputs that pass the synchroniser together
  typedef struct packed {
    logic             ext_irq;
    logic [NSEL-1:0]  jumper;
    logic [NSEL-1:0]  gate;
    logic [NSEL-1:0]  eclk;
    logic [7:0]       din;
  } ccs_pins_t;
endpackage

// ### sim/ccs_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_far_end
  import ccs_pkg::*;
(
  input  wire logic            ext_irq,
  input  wire logic [NSEL-1:0] jumper,
  input  wire logic [NSEL-1:0] gate_open,
  input  wire logic [NSEL-1:0] gate_drv,
  input  wire logic [NSEL-1:0] eclk,
  input  wire logic [7:0]      din,
  output var  ccs_pins_t       pins
);
  // Open gate floats to the pull-up, so it reads enabled
  always_comb
  begin
    pins.ext_irq = ext_irq;
    pins.jumper  = jumper;
    pins.gate    = gate_drv | gate_open;
    pins.eclk    = eclk;
    pins.din     = din;
  end
endmodule
`default_nettype wire

// ### sim/ccs_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_top_monitor
  import ccs_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire ccs_pins_t         pins,
  input wire logic [7:0]        dout,
  input wire logic [NCNT-1:0]   counter_out,
  input wire logic              aux_clock_line,
  input wire logic              irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Bus answer timing, one wait state, one-cycle pulse
  a_pready_one_wait:
    assert property (psel && penable && !pready && ce ##1 ce |-> pready)
    else $error("pready not after one wait state");
  a_pready_one_pulse:
    assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  a_err_needs_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_rdata_zero:
    assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero while idle");
  // Output port follows writes to its own address and holds without any write; input port reads one byte
  a_port_write_lands:
    assert property (pready && ce && pwrite && paddr == ADDR_DIO
      |=> dout == $past(pwdata[7:0]))
    else $error("output port missed write");
  a_port_holds:
    assert property (!(pready && pwrite) |=> $stable(dout))
    else $error("output port changed without write");
  a_port_read_width:
    assert property (pready && !pwrite && paddr == ADDR_DIO
      |-> prdata[31:8] == 24'h00_0000)
    else $error("input port read wider than a byte");
  // Select bytes are write only, so reads give zero
  a_select_write_only:
    assert property (pready && !pwrite && (paddr == ADDR_SEL0
      || paddr == ADDR_SEL1 || paddr == ADDR_SEL2)
      |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("select byte read not zero");
  a_aux_tick_gap:
    assert property (aux_clock_line |=> !aux_clock_line [*8])
    else $error("aux ticks too close");
  // Either reference ticks at least every 125 cycles
  a_aux_tick_due:
    assert property (aux_clock_line |-> ##[1:125] aux_clock_line)
    else $error("aux tick missing");
endmodule
bind ccs_top ccs_top_monitor ccs_top_monitor_i (.clk(clk),
  .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .dout(dout),
  .counter_out(counter_out), .aux_clock_line(aux_clock_line), .irq(irq));
`default_nettype wire

// ### sim/counter_card_clock_select_dio_bench.sv
`timescale 1ns/1ps
`default_nettype none
module counter_card_clock_select_dio_bench;
  import ccs_pkg::*;
  logic              clk = 1'b0, reset_n = 1'b0, ext_irq = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, aux_clock_line, irq, err;
  logic [7:0]        dout, din = 8'h00;
  logic [NCNT-1:0]   counter_out;
  logic [NSEL-1:0]   eclk = '0, gate_open = '1, gate_drv = '0;
  logic [NSEL-1:0]   jumper = '0;
  ccs_pins_t         pins;
  int                bad_count = 0, total_checks = 0, r, p;

  always #2 clk = ~clk;

  ccs_top ccs_top_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .dout(dout), .counter_out(counter_out),
    .aux_clock_line(aux_clock_line), .irq(irq));
  ccs_far_end ccs_far_end_i (.ext_irq(ext_irq), .jumper(jumper),
    .gate_open(gate_open), .gate_drv(gate_drv), .eclk(eclk), .din(din),
    .pins(pins));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One full bus cycle; waits are bounded so a hang ends the run
  task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      bad_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Slow pulses so the pin synchroniser sees each one
  task automatic pulse(int i, int cnt, int w);
    repeat (cnt)
    begin
      eclk[i] <= 1'b1;
      repeat (w) @(posedge clk);
      eclk[i] <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask

  function automatic logic [ADDR_W-1:0] cnt_addr(int n);
    return ADDR_CNT_BASE + ADDR_W'(4 * (n - 1));
  endfunction

  initial
  begin
    void'($urandom(65));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("dout", dout, 0);
    check("counter_out", counter_out, 12'hFFF);
    apb(0, ADDR_SEL0, 0);
    check("select read", rd, 0);
    apb(0, 12'h0004, 0);
    check("unmapped err", err, 1);
    $display("test reset done");
    repeat (4)
    begin
      r = $urandom % 256;
      apb(1, ADDR_DIO, r);
      @(posedge clk);
      check("dout", dout, r);
      din <= 8'($urandom);
      repeat (8) @(posedge clk);
      apb(0, ADDR_DIO, 0);
      check("din", rd, {24'h00_0000, din});
    end
    $display("test port done");
    // External clock for counters 1, 5 and 9, then gate closed
    for (int k = 0; k < 3; k++)
    begin
      apb(1, ADDR_SEL0 + ADDR_W'(4 * k), 8'h80);
      r = 20 + $urandom % 50;
      p = 1 + $urandom % 5;
      apb(1, cnt_addr(1 + 4 * k), r);
      pulse(4 * k, p, 6);
      apb(0, cnt_addr(1 + 4 * k), 0);
      check("ext count", rd, r - p);
      gate_open[4 * k] <= 1'b0;
      pulse(4 * k, 3, 6);
      apb(0, cnt_addr(1 + 4 * k), 0);
      check("gated count", rd, r - p);
      gate_open[4 * k] <= 1'b1;
    end
    // Debounce on: short glitches vanish, long pulses on 8 MHz count
    jumper[0] <= 1'b1;
    apb(1, cnt_addr(1), 30);
    pulse(0, 3, 6);
    apb(1, ADDR_SEL2, 8'h90);
    pulse(0, 2, 120);
    apb(0, cnt_addr(1), 0);
    check("debounced count", rd, 28);
    jumper[0] <= 1'b0;
    // Counter 2 cascaded from counter 1 reloading at 2
    apb(1, ADDR_SEL0, 8'hC2);
    apb(1, cnt_addr(1), 2);
    apb(1, cnt_addr(2), 100);
    pulse(0, 4, 6);
    apb(0, cnt_addr(2), 0);
    check("cascade count", rd, 98);
    $display("test counters done");
    apb(1, ADDR_MASK, 0);
    ext_irq <= 1'b1;
    repeat (10) @(posedge clk);
    check("irq masked", irq, 0);
    apb(0, ADDR_STATUS, 0);
    check("status", rd, 2);
    apb(1, ADDR_MASK, 2);
    repeat (3) @(posedge clk);
    check("irq raised", irq, 1);
    apb(1, ADDR_STATUS, 2);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
    ext_irq <= 1'b0;
    // Counter 11 at reload 1 ripples counter 12 into the status bit
    apb(1, cnt_addr(12), 1);
    apb(1, cnt_addr(11), 1);
    repeat (80) @(posedge clk);
    check("counter 11 out", counter_out[10], 0);
    apb(0, ADDR_STATUS, 0);
    check("counter irq", rd, 1);
    $display("test interrupt done");
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/ccs_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_top
  import ccs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire ccs_pins_t         pins,
  output var  logic [7:0]        dout,
  output var  logic [NCNT-1:0]   counter_out,
  output var  logic              aux_clock_line,
  output var  logic              irq
);

  localparam int PIN_W = $bits(ccs_pins_t);

  logic [7:0]            sel_reg [3];
  logic [PIN_W-1:0]      sync1;
  logic [PIN_W-1:0]      sync2;
  logic [PIN_W-1:0]      sync3;
  logic [PIN_W-1:0]      pin_f;
  ccs_pins_t             pf;
  logic [1:0]            ref_tick;
  logic                  tick_hi;
  logic                  tick_lo;
  logic                  aux_tick;
  logic                  deb_tick;
  logic [NSEL-1:0]       ext_tick;
  logic [NCNT-1:0]       src_tick;
  logic [NCNT-1:0]       gate_on;
  logic [NCNT-1:0]       term;
  logic [CNT_W-1:0]      count  [NCNT];
  logic [CNT_W-1:0]      reload [NCNT];
  logic [NCNT-1:0]       cnt_wr;
  logic [NIRQ-1:0]       status;
  logic [NIRQ-1:0]       mask;
  logic [NIRQ-1:0]       irq_event;
  logic                  ext_irq_prev;
  logic                  wr_en;
  logic                  rd_hit;
  logic [31:0]           rd_data;

  assign pf = ccs_pins_t'(pin_f);

  // Pin synchroniser: three stages, a change counts when stages 2 and 3 agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else if (ce)
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar b;
  generate
    for (b = 0; b < PIN_W; b++)
    begin : g_filt
      // Filtered level holds until two stages agree
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          pin_f[b] <= 1'b0;
        else if (ce && (sync2[b] == sync3[b]))
          pin_f[b] <= sync3[b];
      end
    end
  endgenerate

  // Fixed references by phase accumulation; exact average rate, some jitter
  genvar r;
  generate
    for (r = 0; r < 2; r++)
    begin : g_ref
      localparam int RATE = (r == 0) ? REF_HI_MHZ : REF_LO_MHZ;
      logic [ACC_W-1:0] acc;
      logic [ACC_W-1:0] sum;
      assign sum = acc + ACC_W'(RATE);
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          acc <= '0;
          ref_tick[r] <= 1'b0;
        end
        else if (ce)
        begin
          if (sum >= ACC_W'(CLK_MHZ))
          begin
            acc <= sum - ACC_W'(CLK_MHZ);
            ref_tick[r] <= 1'b1;
          end
          else
          begin
            acc <= sum;
            ref_tick[r] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign tick_hi = ref_tick[0] & ce; // RULE_09
  assign tick_lo = ref_tick[1] & ce; // RULE_10

  // Aux line and debounce clock pick between the two references
  assign aux_tick = sel_reg[2][POS_AUX_SEL] ? tick_lo : tick_hi; // RULE_05
  assign deb_tick = sel_reg[2][POS_DEB_SEL] ? tick_hi : tick_lo; // RULE_05

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      aux_clock_line <= 1'b0;
    else if (ce)
      aux_clock_line <= aux_tick;
  end

  // External clocks: optional debounce, then rising edge gives a tick
  genvar e;
  generate
    for (e = 0; e < NSEL; e++)
    begin : g_ext
      logic samp_a;
      logic samp_b;
      logic deb;
      logic src;
      logic prev;
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          samp_a <= 1'b0;
          samp_b <= 1'b0;
          deb <= 1'b0;
        end
        else if (deb_tick)
        begin
          samp_a <= pf.eclk[e];
          samp_b <= samp_a;
          if (samp_a == samp_b)
            deb <= samp_b; // RULE_13
        end
      end
      // Jumper picks filtered or raw clock
      assign src = pf.jumper[e] ? deb : pf.eclk[e]; // RULE_13
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          prev <= 1'b0;
        else if (ce)
          prev <= src;
      end
      assign ext_tick[e] = src & ~prev & ce;
    end
  endgenerate

  // Counters: source select, gate, reload on terminal count
  genvar c;
  generate
    for (c = 0; c < NCNT; c++)
    begin : g_cnt
      ccs_src_t sel;
      if (c < NSEL)
      begin : g_sel
        logic cas_tick;
        // Counter c: byte c/4, first bit 7-(c%4), second bit c%4
        assign sel = ccs_src_t'({sel_reg[c/4][7-(c%4)], // RULE_02 RULE_03
                                 sel_reg[c/4][c%4]});   // RULE_04 RULE_05
        // Board pull-up makes an open gate read high
        assign gate_on[c] = pf.gate[c]; // RULE_12
        // Split so no counter ever reads its own terminal pulse
        if (c == 0)
        begin : g_cas_first
          assign cas_tick = aux_tick; // RULE_11
        end
        else
        begin : g_cas_next
          assign cas_tick = term[c-1]; // RULE_11
        end
        always_comb
        begin
          case (sel) // RULE_16
            CCS_SRC_HI:  src_tick[c] = tick_hi;
            CCS_SRC_LO:  src_tick[c] = tick_lo;
            CCS_SRC_EXT: src_tick[c] = ext_tick[c];
            CCS_SRC_CAS: src_tick[c] = cas_tick; // RULE_11
            default:     src_tick[c] = 1'b0;
          endcase
        end
      end
      else if (c == NSEL)
      begin : g_fix11
        assign sel = CCS_SRC_HI;
        assign src_tick[c] = tick_hi; // RULE_15
        assign gate_on[c] = 1'b1;
      end
      else
      begin : g_fix12
        assign sel = CCS_SRC_CAS;
        assign src_tick[c] = term[c-1]; // RULE_15
        assign gate_on[c] = 1'b1;
      end

      // Terminal pulse ripples into the next counter in the same cycle
      assign term[c] = src_tick[c] & gate_on[c]
                       & (count[c] == CNT_W'(1)); // RULE_08

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          reload[c] <= RELOAD_RESET;
          count[c] <= RELOAD_RESET;
        end
        else if (ce)
        begin
          if (cnt_wr[c])
          begin
            reload[c] <= pwdata[CNT_W-1:0];
            count[c] <= pwdata[CNT_W-1:0];
          end
          else if (term[c])
            count[c] <= reload[c]; // RULE_08
          else if (src_tick[c] && gate_on[c])
            count[c] <= count[c] - CNT_W'(1); // RULE_08 RULE_12
        end
      end

      // Output low for the last count of each period
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          counter_out[c] <= 1'b1;
        else if (ce)
          counter_out[c] <= (count[c] != CNT_W'(1));
      end

      assign cnt_wr[c] = wr_en
                         && (paddr == ADDR_CNT_BASE + ADDR_W'(4 * c));
    end
  endgenerate

  // APB: one wait state, write lands on the completing edge
  assign wr_en = psel & penable & pready & pwrite & ce;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && penable && !pready)
      begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~rd_hit;
      end
      else
      begin
        pready <= 1'b0;
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // Read mux; select bytes are write-only and read as zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      ADDR_SEL0, ADDR_SEL1, ADDR_SEL2: rd_data = 32'h0000_0000;
      ADDR_DIO:    rd_data = {24'h00_0000, pf.din}; // RULE_06 RULE_07
      ADDR_STATUS: rd_data = {30'h0000_0000, status};
      ADDR_MASK:   rd_data = {30'h0000_0000, mask};
      default:
      begin
        rd_hit = 1'b0;
        for (int k = 0; k < NCNT; k++)
        begin
          if (paddr == ADDR_CNT_BASE + ADDR_W'(4 * k))
          begin
            rd_hit = 1'b1;
            rd_data = {16'h0000, count[k]};
          end
        end
      end
    endcase
  end

  // Clock select bytes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_reg[0] <= SEL_RESET; // RULE_16
      sel_reg[1] <= SEL_RESET;
      sel_reg[2] <= SEL_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_SEL0)
        sel_reg[0] <= pwdata[7:0]; // RULE_01 RULE_03
      if (paddr == ADDR_SEL1)
        sel_reg[1] <= pwdata[7:0]; // RULE_01 RULE_04
      if (paddr == ADDR_SEL2)
        sel_reg[2] <= pwdata[7:0] & 8'hF3; // RULE_01 RULE_05
    end
  end

  // Output port latch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dout <= DOUT_RESET;
    else if (wr_en && (paddr == ADDR_DIO))
      dout <= pwdata[7:0]; // RULE_07
  end

  // Interrupt sources: counter 12 terminal and external rising edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ext_irq_prev <= 1'b0;
    else if (ce)
      ext_irq_prev <= pf.ext_irq;
  end

  assign irq_event[IRQ_INT] = term[NCNT-1]; // RULE_14
  assign irq_event[IRQ_EXT] = pf.ext_irq & ~ext_irq_prev & ce; // RULE_14

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status <= '0;
      mask <= MASK_RESET;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_en && (paddr == ADDR_STATUS))
        status <= (status & ~pwdata[NIRQ-1:0]) | irq_event;
      else
        status <= status | irq_event;
      if (wr_en && (paddr == ADDR_MASK))
        mask <= pwdata[NIRQ-1:0];
      irq <= |(status & mask); // RULE_14
    end
  end

endmodule
`default_nettype wire
